// file: rtl/icd_dma.sv
// dma engine and programmed transfer logic of one io card
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - chain bit reloads after self-configured block
// - command pulse per element when enabled
// - size bit selects byte or word
// - residue bit writes count back
// - completion interrupt unless inhibited or chaining
// - remote bit steers data accesses
// - four-word descriptor adds card control
// - auto bit only used when self-configured
// - self-configured output waits service request unless auto
// - input with auto: command after last
// - direction bit picks input or output
// - user bits stored without function
// - map set field tags data accesses
// - chaining fetches next descriptor from pointer
// - setting dma control starts peripheral
// - each done moves one element
// - set control with clear clears flag
// - programmed control set sends start
// - done sets flag; gated interrupt
// - clear control with clear frees chain
// - control and flag clear at reset
// - negative count ends at zero
// - pointer increments per descriptor word
// - address read top bit complements direction
module icd_dma import icd_pkg::*; (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic io_strobe_in, // one-cycle instruction strobe
  input wire icd_io_req_t io_req_in, // instruction and data
  output logic [15:0] io_rdata_out, // read answer
  output logic flag_status_out, // programmed flag for skip tests
  output logic dma_active_out, // dma engine busy
  input wire logic int_sys_on_in, // interrupt system enabled
  input wire logic prio_in, // priority from higher card
  output logic prio_out, // priority to lower card
  output logic irq_out, // programmed transfer interrupt
  output logic dma_irq_out, // dma completion interrupt
  output logic mem_valid_out, // memory request pending
  output icd_mem_req_t mem_req_out, // memory request
  input wire logic mem_ack_in, // memory done pulse
  input wire logic [15:0] mem_rdata_in, // memory read data
  output logic dev_start_out, // start pulse to peripheral
  output logic dev_cmd_out, // device command pulse
  output logic [15:0] dev_data_out, // data to peripheral
  input wire logic dev_done_in, // done pulse from peripheral
  input wire logic [15:0] dev_data_in, // data from peripheral
  input wire logic device_service_request_in, // peripheral asks service
  output logic [15:0] card_ctl_out // card control word
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT_SRQ,
    ST_RUN,
    ST_RESIDUE
  } icd_state_t;
  icd_state_t state_reg;
  icd_cw1_t cw1_reg;
  icd_mem_req_t mem_next;
  logic [15:0] scp_reg, addr_reg, cnt_reg, dev_cnt_reg, data_reg, fifo_wdata, fifo_rdata;
  logic [1:0] fetch_idx_reg, fetch_pos;
  logic selfcfg_reg, dev_busy_reg, ctl30_reg, flag30_reg, prio_hold_reg;
  logic mem_issue, mem_done, fifo_push, fifo_pop, fifo_in_ready, fifo_out_valid, fifo_flush;
  logic dev_go, dma_done, prog_done, run_end, blk_end;
  logic io_wr, io_rd, stc20, stc21, clc21, stc30, clc30, stf30, clf30;
  // instruction decode
  assign io_wr = io_strobe_in && (io_req_in.op == ICD_IO_OUT);
  assign io_rd = io_strobe_in && (io_req_in.op == ICD_IO_IN);
  assign stc20 = io_strobe_in && (io_req_in.op == ICD_IO_STC) && (io_req_in.sel == ICD_REG_SCP);
  assign stc21 = io_strobe_in && (io_req_in.op == ICD_IO_STC) && (io_req_in.sel == ICD_REG_CW1);
  assign clc21 = io_strobe_in && (io_req_in.op == ICD_IO_CLC) && (io_req_in.sel == ICD_REG_CW1);
  assign stc30 = io_strobe_in && (io_req_in.op == ICD_IO_STC) && (io_req_in.sel == ICD_REG_DATA);
  assign clc30 = io_strobe_in && (io_req_in.op == ICD_IO_CLC) && (io_req_in.sel == ICD_REG_DATA);
  assign stf30 = io_strobe_in && (io_req_in.op == ICD_IO_STF) && (io_req_in.sel == ICD_REG_DATA);
  assign clf30 = io_strobe_in && (io_req_in.op == ICD_IO_CLF) && (io_req_in.sel == ICD_REG_DATA);
  // done belongs to dma while it waits, else to the programmed flag
  assign dma_done = dev_done_in && dev_busy_reg;
  assign prog_done = dev_done_in && !dev_busy_reg && ctl30_reg;
  assign mem_done = mem_valid_out && mem_ack_in;
  assign fetch_pos = 2'(fetch_idx_reg - {1'b0, cw1_reg.fetch_four});
  assign fifo_flush = stc20 || stc21 || clc21;
  // block is over once both sides counted out and the fifo drained
  assign run_end = (state_reg == ST_RUN) && (cnt_reg == ICD_RST16) && (dev_cnt_reg == ICD_RST16)
    && !dev_busy_reg && !fifo_out_valid && !mem_valid_out;
  assign blk_end = (run_end && !cw1_reg.residue_writeback) || ((state_reg == ST_RESIDUE) && mem_done);
  // memory and device issue decisions; fifo sits between them
  always_comb begin
    mem_issue = 1'b0;
    mem_next = '0;
    fifo_pop = 1'b0;
    dev_go = 1'b0;
    if (!mem_valid_out && (state_reg == ST_FETCH)) begin
      mem_issue = 1'b1;
      mem_next.addr = scp_reg;
    end else if (!mem_valid_out && (state_reg == ST_RESIDUE)) begin
      mem_issue = 1'b1;
      mem_next.write = 1'b1;
      mem_next.addr = 16'(scp_reg - ICD_ONE16);
      mem_next.wdata = cnt_reg;
    end else if (!mem_valid_out && (state_reg == ST_RUN) && (cnt_reg != ICD_RST16)) begin
      mem_next.remote = cw1_reg.remote_memory_enable;
      mem_next.map_set = cw1_reg.map_set_select;
      mem_next.byte_mode = cw1_reg.byte_mode;
      mem_next.addr = addr_reg;
      mem_next.write = cw1_reg.dir_in;
      mem_next.wdata = fifo_rdata;
      if (cw1_reg.dir_in) begin
        mem_issue = fifo_out_valid;
        fifo_pop = fifo_out_valid;
      end else begin
        mem_issue = fifo_in_ready; // reserve room before reading
      end
    end
    // one start outstanding at a time; fifo room or data gates it
    if ((state_reg == ST_RUN) && !dev_busy_reg && (dev_cnt_reg != ICD_RST16)) begin
      if (cw1_reg.dir_in) begin
        dev_go = fifo_in_ready;
      end else begin
        dev_go = fifo_out_valid;
        fifo_pop = fifo_out_valid;
      end
    end
  end
  // input data come from the peripheral, output data from memory
  assign fifo_push = cw1_reg.dir_in ? dma_done : ((state_reg == ST_RUN) && mem_done);
  assign fifo_wdata = cw1_reg.dir_in ? dev_data_in : mem_rdata_in;
  icd_fifo #(
    .WIDTH(ICD_DW),
    .DEPTH(ICD_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_wdata),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_rdata)
  );
  // descriptor registers and block sequencer
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_IDLE;
      cw1_reg <= icd_cw1_t'(ICD_RST16);
      scp_reg <= ICD_RST16;
      addr_reg <= ICD_RST16;
      cnt_reg <= ICD_RST16;
      dev_cnt_reg <= ICD_RST16;
      card_ctl_out <= ICD_RST16;
      fetch_idx_reg <= 2'h0;
      selfcfg_reg <= 1'b0;
    end else begin
      if (io_wr) begin
        case (io_req_in.sel)
          ICD_REG_SCP: scp_reg <= io_req_in.data;
          ICD_REG_CW1: cw1_reg <= icd_cw1_t'(io_req_in.data);
          ICD_REG_ADDR: addr_reg <= io_req_in.data;
          ICD_REG_CNT: cnt_reg <= io_req_in.data;
          ICD_REG_CARD: card_ctl_out <= io_req_in.data;
          default: ;
        endcase
      end
      if (clc21) begin
        state_reg <= ST_IDLE;
      end else if (stc20) begin
        state_reg <= ST_FETCH;
        selfcfg_reg <= 1'b1;
        fetch_idx_reg <= 2'h0;
      end else if (stc21) begin
        state_reg <= ST_RUN;
        selfcfg_reg <= 1'b0;
        dev_cnt_reg <= cnt_reg;
      end else begin
        unique case (state_reg)
          ST_IDLE: ;
          ST_FETCH: begin
            if (mem_done) begin
              scp_reg <= 16'(scp_reg + ICD_ONE16);
              fetch_idx_reg <= 2'(fetch_idx_reg + 2'h1);
              if (fetch_idx_reg == 2'h0) begin
                cw1_reg <= icd_cw1_t'(mem_rdata_in);
              end else if (fetch_pos == ICD_POS_CARD) begin
                card_ctl_out <= mem_rdata_in;
              end else if (fetch_pos == ICD_POS_ADDR) begin
                addr_reg <= mem_rdata_in;
              end else begin
                cnt_reg <= mem_rdata_in;
                dev_cnt_reg <= mem_rdata_in;
                // auto matters here and for the last input command, both only in a self-configured block
                if (!cw1_reg.dir_in && !cw1_reg.auto_start) begin
                  state_reg <= ST_WAIT_SRQ;
                end else begin
                  state_reg <= ST_RUN;
                end
              end
            end
          end
          ST_WAIT_SRQ: begin
            if (device_service_request_in) state_reg <= ST_RUN;
          end
          ST_RUN: begin
            if (mem_done) begin
              addr_reg <= 16'(addr_reg + ICD_ONE16);
              cnt_reg <= 16'(cnt_reg + ICD_ONE16);
            end
            if (dma_done) dev_cnt_reg <= 16'(dev_cnt_reg + ICD_ONE16);
            if (run_end) state_reg <= ST_RESIDUE;
          end
          ST_RESIDUE: ;
        endcase
        // chaining reloads only after a self-configured block
        if (blk_end) begin
          state_reg <= (cw1_reg.chain_continue && selfcfg_reg) ? ST_FETCH : ST_IDLE;
          fetch_idx_reg <= 2'h0;
        end
      end
    end
  end
  // memory request holds until acknowledged
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_valid_out <= 1'b0;
      mem_req_out <= '0;
    end else if (mem_issue) begin
      mem_valid_out <= 1'b1;
      mem_req_out <= mem_next;
    end else if (mem_ack_in) begin
      mem_valid_out <= 1'b0;
    end
  end
  // peripheral handshake: start, done and command pulses
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dev_busy_reg <= 1'b0;
      dev_start_out <= 1'b0;
      dev_cmd_out <= 1'b0;
      dev_data_out <= ICD_RST16;
    end else begin
      if (clc21 || dev_go) begin
        dev_busy_reg <= dev_go;
      end else if (dma_done) begin
        dev_busy_reg <= 1'b0;
      end
      dev_start_out <= dev_go || stc30;
      if (dev_go && !cw1_reg.dir_in) begin
        dev_data_out <= fifo_rdata;
      end else if (stc30) begin
        dev_data_out <= data_reg;
      end
      dev_cmd_out <= dma_done && (cw1_reg.per_element_device_command || (cw1_reg.dir_in
        && cw1_reg.auto_start && selfcfg_reg && (dev_cnt_reg == ICD_NEG1)));
    end
  end
  // completion flag; a new completion beats a restart clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dma_irq_out <= 1'b0;
      dma_active_out <= 1'b0;
    end else begin
      if (blk_end && !cw1_reg.completion_irq_inhibit && !cw1_reg.chain_continue) begin
        dma_irq_out <= 1'b1;
      end else if (stc20 || stc21 || clc21) begin
        dma_irq_out <= 1'b0;
      end
      dma_active_out <= (state_reg != ST_IDLE);
    end
  end
  // programmed transfer control and flag; a done beats a clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl30_reg <= 1'b0;
      flag30_reg <= 1'b0;
      data_reg <= ICD_RST16;
    end else begin
      if (stc30) ctl30_reg <= 1'b1;
      else if (clc30) ctl30_reg <= 1'b0;
      if (prog_done || stf30) begin
        flag30_reg <= 1'b1;
      end else if (clf30 || ((stc30 || clc30) && io_req_in.clr_flag)) begin
        flag30_reg <= 1'b0;
      end
      if (prog_done) data_reg <= dev_data_in;
      else if (io_wr && (io_req_in.sel == ICD_REG_DATA)) data_reg <= io_req_in.data;
    end
  end
  // interrupt gating and priority chain
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
      prio_hold_reg <= 1'b0;
      prio_out <= 1'b0;
      flag_status_out <= 1'b0;
    end else begin
      irq_out <= flag30_reg && ctl30_reg && int_sys_on_in && prio_in;
      if (flag30_reg && ctl30_reg && !clc30) begin
        prio_hold_reg <= 1'b1;
      end else if (clc30 && io_req_in.clr_flag) begin
        prio_hold_reg <= 1'b0;
      end
      prio_out <= prio_in && !prio_hold_reg;
      flag_status_out <= flag30_reg;
    end
  end
  // register read answer, one cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_rdata_out <= ICD_RST16;
    end else if (io_rd) begin
      case (io_req_in.sel)
        ICD_REG_SCP: io_rdata_out <= scp_reg;
        ICD_REG_CW1: io_rdata_out <= cw1_reg;
        ICD_REG_ADDR: io_rdata_out <= {!cw1_reg.dir_in, addr_reg[14:0]};
        ICD_REG_CNT: io_rdata_out <= cnt_reg;
        ICD_REG_DATA: io_rdata_out <= data_reg;
        ICD_REG_CARD: io_rdata_out <= card_ctl_out;
        default: io_rdata_out <= ICD_RST16;
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_prog_done_enabled;
    prog_done ##1 (ctl30_reg && int_sys_on_in && prio_in && !clc30);
  endsequence

  sequence s_last_fetch;
    (state_reg == ST_FETCH) && mem_done && (fetch_idx_reg != 2'h0) && (fetch_pos == ICD_POS_CNT)
      && !clc21 && !stc20 && !stc21;
  endsequence

  AST_START_ON_STC30: assert property (stc30 |=> dev_start_out)
    else $error("no start after programmed control set");
  AST_DONE_IRQ: assert property (s_prog_done_enabled |=> irq_out)
    else $error("flag did not raise interrupt");
  AST_IRQ_GATE: assert property (irq_out |-> $past(flag30_reg && ctl30_reg && prio_in))
    else $error("interrupt without flag, control and priority");
  AST_STC_CLR: assert property (stc30 && io_req_in.clr_flag && !prog_done |=> ctl30_reg && !flag30_reg)
    else $error("set control with clear misbehaved");
  AST_CLC_CLR: assert property (clc30 && io_req_in.clr_flag && !prog_done |=> !ctl30_reg && !flag30_reg ##1 prio_out == prio_in)
    else $error("clear control with clear misbehaved");
  AST_CNT_ADV: assert property ((state_reg == ST_RUN) && mem_done && !clc21 && !stc20 && !stc21 && !io_wr
    |=> cnt_reg == 16'($past(cnt_reg) + ICD_ONE16) && addr_reg == 16'($past(addr_reg) + ICD_ONE16))
    else $error("count or address did not advance");
  AST_CMD_PER_ELEM: assert property (dma_done && cw1_reg.per_element_device_command |=> dev_cmd_out)
    else $error("missing device command");
  AST_CMD_CAUSE: assert property (dev_cmd_out |-> $past(dma_done))
    else $error("device command without element");
  AST_SCP_INC: assert property ((state_reg == ST_FETCH) && mem_done && !clc21 && !stc20 && !stc21 && !io_wr
    |=> scp_reg == 16'($past(scp_reg) + ICD_ONE16))
    else $error("pointer did not advance");
  AST_SRQ_WAIT: assert property (s_last_fetch ##0 (!cw1_reg.dir_in && !cw1_reg.auto_start)
    |=> (state_reg == ST_WAIT_SRQ) && !dev_start_out)
    else $error("output started without service request");
  AST_ADDR_DIR: assert property (io_rd && (io_req_in.sel == ICD_REG_ADDR) && (state_reg != ST_FETCH)
    |=> io_rdata_out[15] == !$past(cw1_reg.dir_in))
    else $error("address top bit not inverted direction");
endmodule : icd_dma
`default_nettype wire

// file: rtl/icd_pkg.sv
// shared constants and types for the io card dma block
package icd_pkg;
  // fixed data path sizes
  localparam int unsigned ICD_DW = 16;
  localparam int unsigned ICD_FIFO_DEPTH = 8;

  // card register numbers (octal 20..23, 30, 31 written in hex)
  localparam logic [5:0] ICD_REG_SCP = 6'h10; // self-configuration pointer
  localparam logic [5:0] ICD_REG_CW1 = 6'h11; // dma control word
  localparam logic [5:0] ICD_REG_ADDR = 6'h12; // dma memory address
  localparam logic [5:0] ICD_REG_CNT = 6'h13; // negative element count
  localparam logic [5:0] ICD_REG_DATA = 6'h18; // programmed data buffer
  localparam logic [5:0] ICD_REG_CARD = 6'h19; // card control word

  // reset values and count constants
  localparam logic [15:0] ICD_RST16 = 16'h0000;
  localparam logic [15:0] ICD_ONE16 = 16'h0001;
  localparam logic [15:0] ICD_NEG1 = 16'hffff;

  // descriptor word positions after the control word
  localparam logic [1:0] ICD_POS_CARD = 2'h0;
  localparam logic [1:0] ICD_POS_ADDR = 2'h1;
  localparam logic [1:0] ICD_POS_CNT = 2'h2;

  // i/o instruction kinds
  typedef enum logic [2:0] {
    ICD_IO_OUT,
    ICD_IO_IN,
    ICD_IO_STC,
    ICD_IO_CLC,
    ICD_IO_STF,
    ICD_IO_CLF
  } icd_io_op_t;

  // one i/o instruction as seen by the card
  typedef struct packed {
    icd_io_op_t op;
    logic [5:0] sel;
    logic clr_flag;
    logic [15:0] data;
  } icd_io_req_t;

  // dma control word layout, bit 15 first
  typedef struct packed {
    logic chain_continue;
    logic per_element_device_command;
    logic byte_mode;
    logic residue_writeback;
    logic completion_irq_inhibit;
    logic remote_memory_enable;
    logic fetch_four;
    logic auto_start;
    logic dir_in;
    logic [1:0] user_bits;
    logic [4:0] map_set_select;
  } icd_cw1_t;

  // one memory request
  typedef struct packed {
    logic write;
    logic remote;
    logic byte_mode;
    logic [4:0] map_set;
    logic [15:0] addr;
    logic [15:0] wdata;
  } icd_mem_req_t;
endpackage : icd_pkg

// file: rtl/icd_fifo.sv
// small synchronous fifo with registered head word
`timescale 1ns/1ps
`default_nettype none
module icd_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic flush_in, // drop all contents
  input wire logic in_valid_in, // write request
  output logic in_ready_out, // room for a word
  input wire logic [WIDTH-1:0] in_data_in, // write data
  output logic out_valid_out, // head word present
  input wire logic out_ready_in, // head consumed
  output logic [WIDTH-1:0] out_data_out // head word, registered
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] rd_ptr_next;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  // handshakes gate on honest full and empty
  assign in_ready_out = (count_reg != FULL_CNT);
  assign out_valid_out = (count_reg != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

  // storage array, written only
  always_ff @(posedge clk_in) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
    end
  end

  // head register forwards a write into the slot being read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_data_out <= '0;
    end else if (push && (wr_ptr_reg == rd_ptr_next)) begin
      out_data_out <= in_data_in;
    end else begin
      out_data_out <= store_reg[rd_ptr_next];
    end
  end
endmodule : icd_fifo
`default_nettype wire

// file: test/icd_periph.sv
// behavioural peripheral answering start pulses with done
`timescale 1ns/1ps
`default_nettype none
module icd_periph (
  input wire logic clk_in, // system clock
  input wire logic start_in, // start pulse
  input wire logic cmd_in, // device command pulse
  input wire logic [15:0] data_in, // data from card
  output logic done_out, // done pulse
  output logic [15:0] data_out // data to card
);
  logic [15:0] got[$];
  logic [15:0] sent[$];
  logic [15:0] v;
  int cmds = 0;
  int seed = 32'h5cea5754;
  int wt;
  // count command pulses
  always @(posedge clk_in) begin
    if (cmd_in === 1'b1) cmds++;
  end
  // random 1..3 cycle answer; idle data inverted so no stale value passes
  initial begin
    done_out = 1'b0;
    data_out = 16'h0000;
    forever begin
      @(posedge clk_in);
      if (start_in === 1'b1) begin
        got.push_back(data_in);
        wt = 1 + $unsigned($random(seed)) % 3;
        v = 16'($random(seed));
        repeat (wt) @(posedge clk_in);
        done_out <= 1'b1;
        data_out <= v;
        sent.push_back(v);
        @(posedge clk_in);
        done_out <= 1'b0;
        data_out <= ~v;
      end
    end
  end
endmodule : icd_periph
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the io card dma block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb import icd_pkg::*; ;
  logic clk_in = 0, reset_n_in = 0, io_strobe_in = 0, int_sys_on_in = 1, prio_in = 1, mem_ack_in = 0;
  icd_io_req_t io_req_in = '0;
  icd_mem_req_t mem_req_out, last;
  logic [15:0] mem_rdata_in = 0, io_rdata_out, dev_data_out, dev_data_in, card_ctl_out, r;
  logic flag_status_out, dma_active_out, prio_out, irq_out, dma_irq_out, mem_valid_out;
  logic dev_start_out, dev_cmd_out, dev_done_in, device_service_request_in = 0;
  logic [15:0] mem [0:255];
  int err_total = 0, checked = 0, seed = 32'h5cea5754, i, g, c0;
  always #5 clk_in = ~clk_in;
  icd_dma dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .io_strobe_in(io_strobe_in), .io_req_in(io_req_in),
    .io_rdata_out(io_rdata_out), .flag_status_out(flag_status_out), .dma_active_out(dma_active_out),
    .int_sys_on_in(int_sys_on_in), .prio_in(prio_in), .prio_out(prio_out), .irq_out(irq_out),
    .dma_irq_out(dma_irq_out), .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .dev_start_out(dev_start_out),
    .dev_cmd_out(dev_cmd_out), .dev_data_out(dev_data_out), .dev_done_in(dev_done_in),
    .dev_data_in(dev_data_in), .device_service_request_in(device_service_request_in), .card_ctl_out(card_ctl_out));
  icd_periph p (.clk_in(clk_in), .start_in(dev_start_out), .cmd_in(dev_cmd_out), .data_in(dev_data_out),
    .done_out(dev_done_in), .data_out(dev_data_in));
  // memory answers one cycle after a request, ack pulse of one cycle
  always @(posedge clk_in) begin
    mem_ack_in <= 1'b0;
    if (mem_valid_out === 1'b1 && !mem_ack_in) begin
      mem_ack_in <= 1'b1;
      mem_rdata_in <= mem[mem_req_out.addr[7:0]];
      if (mem_req_out.write) mem[mem_req_out.addr[7:0]] <= mem_req_out.wdata;
      last <= mem_req_out;
    end
  end
  // expected address read-back after n elements
  function automatic logic [15:0] aexp(input logic [15:0] cw, input logic [15:0] a, input int n);
    return {~cw[7], a[14:0] + 15'(n)};
  endfunction : aexp
  task io(input icd_io_op_t op, input logic [5:0] s, input logic c, input logic [15:0] d);
    @(posedge clk_in);
    io_strobe_in <= 1'b1;
    io_req_in <= '{op, s, c, d};
    @(posedge clk_in);
    io_strobe_in <= 1'b0;
  endtask : io
  task rd(input logic [5:0] s);
    io(ICD_IO_IN, s, 1'b0, ICD_RST16);
    @(posedge clk_in);
    #1 r = io_rdata_out;
  endtask : rd
  // bounded wait for the engine to go idle
  task idle;
    int k;
    repeat (4) @(posedge clk_in);
    for (k = 0; k < 400 && dma_active_out === 1'b1; k++) @(posedge clk_in);
    if (k == 400) err_total++;
  endtask : idle
  // plain dma block, then address and count read-back
  task run(input logic [15:0] cw, input logic [15:0] a, input int n);
    io(ICD_IO_OUT, ICD_REG_CW1, 1'b0, cw);
    io(ICD_IO_OUT, ICD_REG_ADDR, 1'b0, a);
    io(ICD_IO_OUT, ICD_REG_CNT, 1'b0, 16'(-n));
    io(ICD_IO_STC, ICD_REG_CW1, 1'b1, ICD_RST16);
    idle;
    rd(ICD_REG_ADDR);
    `CHK(r, aexp(cw, a, n))
    rd(ICD_REG_CNT);
    `CHK(r, ICD_RST16)
  endtask : run
  task end_of_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  initial begin
    for (i = 0; i < 256; i++) mem[i] = 16'($random(seed));
    mem[8'h40] = 16'h0100;
    mem[8'h41] = 16'h0050;
    mem[8'h42] = 16'hffff;
    // quadruplet: chain, residue, no auto; then an auto input triplet
    mem[8'h44] = 16'h9200;
    mem[8'h45] = 16'h1234;
    mem[8'h46] = 16'h0050;
    mem[8'h47] = 16'hffff;
    mem[8'h48] = 16'h0180;
    mem[8'h49] = 16'h0051;
    mem[8'h4a] = 16'hfffe;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    #1 `CHK(flag_status_out, 1'b0)
    // programmed transfer: flag set first, then start with clear
    io(ICD_IO_STF, ICD_REG_DATA, 1'b0, ICD_RST16);
    repeat (2) @(posedge clk_in);
    io(ICD_IO_STC, ICD_REG_DATA, 1'b1, ICD_RST16);
    @(posedge clk_in);
    #1 `CHK(flag_status_out, 1'b0)
    for (i = 0; i < 50 && flag_status_out !== 1'b1; i++) @(posedge clk_in);
    @(posedge clk_in);
    #1 `CHK(flag_status_out, 1'b1)
    `CHK(irq_out, 1'b1)
    `CHK(prio_out, 1'b0)
    int_sys_on_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 `CHK(irq_out, 1'b0)
    int_sys_on_in <= 1'b1;
    rd(ICD_REG_DATA);
    `CHK(r, p.sent[$])
    io(ICD_IO_CLC, ICD_REG_DATA, 1'b1, ICD_RST16);
    repeat (2) @(posedge clk_in);
    #1 `CHK(flag_status_out, 1'b0)
    `CHK(prio_out, 1'b1)
    // output block, word mode, map set 3
    g = p.got.size();
    run(16'h0003, 16'h0020, 3);
    for (i = 0; i < 3; i++) `CHK(p.got[g + i], mem[8'h20 + i])
    `CHK(last.map_set, 5'h03)
    `CHK(last.remote, 1'b0)
    `CHK(dma_irq_out, 1'b1)
    // input block: byte, remote, inhibit, command, auto ignored
    g = p.sent.size();
    c0 = p.cmds;
    run(16'h6d85, 16'h0060, 2);
    for (i = 0; i < 2; i++) `CHK(mem[8'h60 + i][7:0], p.sent[g + i][7:0])
    `CHK(last.byte_mode, 1'b1)
    `CHK(last.remote, 1'b1)
    `CHK(last.map_set, 5'h05)
    `CHK(p.cmds - c0, 2)
    `CHK(dma_irq_out, 1'b0)
    // self-configured triplet with automatic output start
    g = p.got.size();
    io(ICD_IO_OUT, ICD_REG_SCP, 1'b0, 16'h0040);
    io(ICD_IO_STC, ICD_REG_SCP, 1'b1, ICD_RST16);
    idle;
    rd(ICD_REG_SCP);
    `CHK(r, 16'h0043)
    `CHK(p.got[g], mem[8'h50])
    // quadruplet holds for service request, writes residue, then chains
    g = p.got.size();
    c0 = p.cmds;
    io(ICD_IO_OUT, ICD_REG_SCP, 1'b0, 16'h0044);
    io(ICD_IO_STC, ICD_REG_SCP, 1'b1, ICD_RST16);
    repeat (30) @(posedge clk_in);
    `CHK(p.got.size(), g)
    device_service_request_in <= 1'b1;
    idle;
    device_service_request_in <= 1'b0;
    rd(ICD_REG_SCP);
    `CHK(r, 16'h004b)
    `CHK(card_ctl_out, 16'h1234)
    `CHK(mem[8'h47], ICD_RST16)
    `CHK(p.got[g], mem[8'h50])
    for (i = 0; i < 2; i++) `CHK(mem[8'h51 + i], p.sent[p.sent.size() - 2 + i])
    `CHK(p.cmds - c0, 1)
    `CHK(dma_irq_out, 1'b1)
    end_of_test;
  end
endmodule : tb
`default_nettype wire
